//--- rtl/cmd_protect_standby_frame_memory_cfg.sv
// cmd_protect_standby_frame_memory_cfg: protect, deep standby and memory access commands.
// assumes host pins already synchronous to i_clk; window bounds and
// frame timing come from neighbouring blocks.
// Functional notes
// R01: b0 parameter bits 1:0 load the protect level.
// R02: 00-b0 always pass; levels 1,2,3 block f0-ff, e0-ff, b1-ff.
// R03: protect level clears on hardware reset only.
// R04: b1 with bit 0 set enters deep standby.
// R05: deep standby keeps no memory or settings.
// R06: host reloads settings and memory after deep standby.
// R07: standby request clears on hardware reset only.
// R08: host requests standby only while sleeping.
// R09: these commands pass in every display and sleep state.
// R10: b3 takes wrap, tear, write cycle and format bytes.
// R11: wrap clear drops pixels past the window.
// R12: wrap set restarts at window start and keeps writing.
// R13: tear pulses every 1, 2, 4 or 6 frames.
// R14: write cycle 011,101,110,111 gives 4,6,7,8 frames.
// R15: one bit selects pixel format for 16-bit and serial buses.
// R16: expansion 00 copies red and blue msb into lsb.
// R17: expansion 01 appends zero, full scale kept.
// R18: expansion 10 appends one, zero kept.
// R19: tear output carries vertical blanking only.
// R20: a blocked command and its parameters change nothing.
// R21: commands with select low, parameters on strobe rising edges.
// R22: host never writes expansion code 11.
`timescale 1ns/1ns
`default_nettype none
module cmd_protect_standby_frame_memory_cfg #(
    parameter int ADDR_W = 9,
    parameter int FRAME_W = 3
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_chip_select_n,
    input wire logic i_cmd_data_select,
    input wire logic i_write_strobe,
    input wire logic [15:0] i_data,
    input wire logic i_sleep_in,
    input wire logic i_vblank,
    input wire logic i_frame_start,
    input wire logic [ADDR_W-1:0] i_window_col_start,
    input wire logic [ADDR_W-1:0] i_window_col_end,
    input wire logic [ADDR_W-1:0] i_window_page_start,
    input wire logic [ADDR_W-1:0] i_window_page_end,
    output logic [1:0] o_protect_level,
    output logic o_deep_sleep_req,
    output logic o_window_wrap_mode,
    output logic [2:0] o_tear_interval,
    output logic [2:0] o_frame_memory_write_cycle,
    output logic [3:0] o_write_cycle_frames,
    output logic o_pixel_transfer_format,
    output logic [1:0] o_color_expand_format,
    output logic o_tear_output,
    output logic o_cmd_rejected,
    output logic o_pix_valid,
    output logic [17:0] o_pix_data,
    output logic [ADDR_W-1:0] o_pix_col,
    output logic [ADDR_W-1:0] o_pix_page
);
    logic rst_meta_q, rst_sync_q;
    logic strobe_prev_q;
    logic wr_edge, cmd_byte, par_byte;
    logic [7:0] byte_in;
    cpsg_pkg::cpsg_state_t state_q, state_d;
    logic [1:0] protect_q;
    logic standby_q;
    logic wrap_q;
    logic [2:0] tear_q;
    logic [2:0] cycle_q;
    logic fmt_q;
    logic [1:0] expand_q;
    logic [FRAME_W-1:0] frame_cnt_q;
    logic tear_q_out;
    logic rejected_q;
    logic pix_valid_q;
    logic [17:0] pix_data_q;
    logic [ADDR_W-1:0] pix_col_q, pix_page_q;

    cpsg_pix_if #(.ADDR_W(ADDR_W)) px ();

    // protect level gate
    function automatic logic cmd_allowed(input logic [1:0] level, input logic [7:0] code);
        case (level)
            cpsg_pkg::LEVEL_OPEN: cmd_allowed = 1'b1;
            cpsg_pkg::LEVEL_HI: cmd_allowed = code < cpsg_pkg::RANGE_MAKER_HI;
            cpsg_pkg::LEVEL_MID: cmd_allowed = code < cpsg_pkg::RANGE_MAKER_MID;
            cpsg_pkg::LEVEL_ALL: cmd_allowed = code < cpsg_pkg::RANGE_MAKER_LO;
            default: cmd_allowed = 1'b1;
        endcase
    endfunction : cmd_allowed

    // tear code to frames, prohibited as one
    function automatic logic [FRAME_W-1:0] tear_frames(input logic [2:0] code);
        case (code)
            3'h0: tear_frames = FRAME_W'(1);
            3'h1: tear_frames = FRAME_W'(2);
            3'h3: tear_frames = FRAME_W'(4);
            3'h5: tear_frames = FRAME_W'(6);
            default: tear_frames = FRAME_W'(1);
        endcase
    endfunction : tear_frames

    // write cycle code to frames, others zero
    function automatic logic [3:0] cycle_frames(input logic [2:0] code);
        case (code)
            3'h3: cycle_frames = 4'h4;
            3'h5: cycle_frames = 4'h6;
            3'h6: cycle_frames = 4'h7;
            3'h7: cycle_frames = 4'h8;
            default: cycle_frames = 4'h0;
        endcase
    endfunction : cycle_frames

    // reset release through two flops
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // R21: strobe rising edge takes a byte
    always_ff @(posedge i_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            strobe_prev_q <= 1'b1;
        end else begin
            strobe_prev_q <= i_write_strobe;
        end
    end

    // R05: nothing is taken while in deep standby
    assign wr_edge = i_write_strobe && !strobe_prev_q && !i_chip_select_n && !standby_q;
    assign cmd_byte = wr_edge && !i_cmd_data_select;
    assign par_byte = wr_edge && i_cmd_data_select;
    assign byte_in = i_data[7:0];

    // parameter sequencer
    always_comb begin
        state_d = state_q;
        if (cmd_byte) begin
            // R02: protect level gates decode
            if (!cmd_allowed(protect_q, byte_in)) begin
                // R20: blocked command skipped whole
                state_d = cpsg_pkg::ST_SKIP;
            end else begin
                case (byte_in)
                    // R01: protect command
                    cpsg_pkg::CMD_PROTECT: state_d = cpsg_pkg::ST_PROT;
                    // R04: standby command
                    cpsg_pkg::CMD_STANDBY: state_d = cpsg_pkg::ST_STBY;
                    // R10: access setup command
                    cpsg_pkg::CMD_FRAME_MEMORY_CFG: state_d = cpsg_pkg::ST_CFG1;
                    cpsg_pkg::CMD_MEM_WRITE: state_d = cpsg_pkg::ST_PIXEL;
                    default: state_d = cpsg_pkg::ST_IDLE;
                endcase
            end
        end else if (par_byte) begin
            case (state_q)
                cpsg_pkg::ST_PROT: state_d = cpsg_pkg::ST_IDLE;
                cpsg_pkg::ST_STBY: state_d = cpsg_pkg::ST_IDLE;
                cpsg_pkg::ST_CFG1: state_d = cpsg_pkg::ST_CFG2;
                cpsg_pkg::ST_CFG2: state_d = cpsg_pkg::ST_CFG3;
                cpsg_pkg::ST_CFG3: state_d = cpsg_pkg::ST_CFG4;
                cpsg_pkg::ST_CFG4: state_d = cpsg_pkg::ST_IDLE;
                default: state_d = state_q;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= cpsg_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // blocked command pulse
    always_ff @(posedge i_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rejected_q <= 1'b0;
        end else begin
            rejected_q <= cmd_byte && !cmd_allowed(protect_q, byte_in);
        end
    end

    // R03: only hardware reset clears the level
    always_ff @(posedge i_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            protect_q <= cpsg_pkg::PROTECT_RST;
        end else if (par_byte && state_q == cpsg_pkg::ST_PROT) begin
            // R01: low two bits loaded
            protect_q <= byte_in[cpsg_pkg::PROT_LSB +: 2];
        end
    end

    // R07: request cleared by hardware reset only
    always_ff @(posedge i_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            standby_q <= cpsg_pkg::STANDBY_RST;
        end else if (par_byte && state_q == cpsg_pkg::ST_STBY) begin
            // R04: bit 0 enters standby
            // R09: taken in any display state
            // R08: sleep entry left to the host
            standby_q <= byte_in[cpsg_pkg::STBY_BIT];
        end
    end

    // frame memory access setup fields
    always_ff @(posedge i_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            wrap_q <= cpsg_pkg::WRAP_RST;
            tear_q <= cpsg_pkg::TEAR_RST;
            cycle_q <= cpsg_pkg::CYCLE_RST;
            fmt_q <= cpsg_pkg::FMT_RST;
            expand_q <= cpsg_pkg::EXP_RST;
        end else if (standby_q) begin
            // R05: settings dropped in standby
            wrap_q <= cpsg_pkg::WRAP_RST;
            tear_q <= cpsg_pkg::TEAR_RST;
            cycle_q <= cpsg_pkg::CYCLE_RST;
            fmt_q <= cpsg_pkg::FMT_RST;
            expand_q <= cpsg_pkg::EXP_RST;
        end else if (par_byte) begin
            // R10: four parameter bytes in order
            case (state_q)
                cpsg_pkg::ST_CFG1: wrap_q <= byte_in[cpsg_pkg::WRAP_BIT];
                cpsg_pkg::ST_CFG2: tear_q <= byte_in[cpsg_pkg::TEAR_LSB +: 3];
                // R14: write cycle code
                cpsg_pkg::ST_CFG3: cycle_q <= byte_in[cpsg_pkg::CYCLE_LSB +: 3];
                cpsg_pkg::ST_CFG4: begin
                    // R15: format select bit
                    fmt_q <= byte_in[cpsg_pkg::FMT_BIT];
                    // R22: code 11 left to the host
                    expand_q <= byte_in[cpsg_pkg::EXP_LSB +: 2];
                end
                default: fmt_q <= fmt_q;
            endcase
        end
    end

    // R13: frame counter for tear interval
    always_ff @(posedge i_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            frame_cnt_q <= '0;
        end else if (i_frame_start) begin
            if (frame_cnt_q >= tear_frames(tear_q) - FRAME_W'(1)) begin
                frame_cnt_q <= '0;
            end else begin
                frame_cnt_q <= frame_cnt_q + FRAME_W'(1);
            end
        end
    end

    // R19: tear follows blanking only, held low in sleep
    always_ff @(posedge i_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            tear_q_out <= 1'b0;
        end else begin
            tear_q_out <= i_vblank && !i_sleep_in && frame_cnt_q == '0;
        end
    end

    // pixel path into expander and walker
    assign px.pix565 = i_data;
    assign px.expand = expand_q;
    assign px.pix_valid = par_byte && state_q == cpsg_pkg::ST_PIXEL;
    assign px.restart = cmd_byte && byte_in == cpsg_pkg::CMD_MEM_WRITE;
    assign px.wrap = wrap_q;
    assign px.col_start = i_window_col_start;
    assign px.col_end = i_window_col_end;
    assign px.page_start = i_window_page_start;
    assign px.page_end = i_window_page_end;

    cpsg_color_expand u_expand (
        .px(px)
    );

    cpsg_window_walker #(.ADDR_W(ADDR_W)) u_walker (
        .i_clk(i_clk),
        .i_rst_n(rst_sync_q),
        .px(px)
    );

    // R11: pixels past the window never leave
    always_ff @(posedge i_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pix_valid_q <= 1'b0;
            pix_data_q <= '0;
            pix_col_q <= '0;
            pix_page_q <= '0;
        end else begin
            pix_valid_q <= px.pix_valid && px.keep;
            if (px.pix_valid && px.keep) begin
                pix_data_q <= px.pix666;
                pix_col_q <= px.col;
                pix_page_q <= px.page;
            end
        end
    end

    assign o_protect_level = protect_q;
    assign o_deep_sleep_req = standby_q;
    assign o_window_wrap_mode = wrap_q;
    assign o_tear_interval = tear_q;
    assign o_frame_memory_write_cycle = cycle_q;
    assign o_write_cycle_frames = cycle_frames(cycle_q);
    assign o_pixel_transfer_format = fmt_q;
    assign o_color_expand_format = expand_q;
    assign o_tear_output = tear_q_out;
    assign o_cmd_rejected = rejected_q;
    assign o_pix_valid = pix_valid_q;
    assign o_pix_data = pix_data_q;
    assign o_pix_col = pix_col_q;
    assign o_pix_page = pix_page_q;
endmodule : cmd_protect_standby_frame_memory_cfg
`default_nettype wire

//--- rtl/cpsg_pkg.sv
// cpsg_pkg: command codes, field positions and reset values.
// assumes byte-wide commands on the low lanes of the host data bus.
package cpsg_pkg;
    localparam logic [7:0] CMD_SW_RESET = 8'h01;
    localparam logic [7:0] CMD_MEM_WRITE = 8'h2c;
    localparam logic [7:0] CMD_PROTECT = 8'hb0;
    localparam logic [7:0] CMD_STANDBY = 8'hb1;
    localparam logic [7:0] CMD_FRAME_MEMORY_CFG = 8'hb3;
    // first code of each protected range
    localparam logic [7:0] RANGE_MAKER_LO = 8'hb1;
    localparam logic [7:0] RANGE_MAKER_MID = 8'he0;
    localparam logic [7:0] RANGE_MAKER_HI = 8'hf0;
    localparam logic [1:0] LEVEL_OPEN = 2'h0;
    localparam logic [1:0] LEVEL_HI = 2'h1;
    localparam logic [1:0] LEVEL_MID = 2'h2;
    localparam logic [1:0] LEVEL_ALL = 2'h3;
    // parameter field positions
    localparam int PROT_LSB = 0;
    localparam int STBY_BIT = 0;
    localparam int WRAP_BIT = 1;
    localparam int TEAR_LSB = 0;
    localparam int CYCLE_LSB = 0;
    localparam int FMT_BIT = 0;
    localparam int EXP_LSB = 4;
    // values after power-on or hardware reset
    localparam logic [1:0] PROTECT_RST = 2'h0;
    localparam logic STANDBY_RST = 1'h0;
    localparam logic WRAP_RST = 1'h0;
    localparam logic [2:0] TEAR_RST = 3'h0;
    localparam logic [2:0] CYCLE_RST = 3'h3;
    localparam logic FMT_RST = 1'h0;
    localparam logic [1:0] EXP_RST = 2'h0;
    // colour expansion codes
    localparam logic [1:0] EXP_MSB = 2'h0;
    localparam logic [1:0] EXP_ZERO = 2'h1;
    localparam logic [1:0] EXP_ONE = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_PROT = 4'h1,
        ST_STBY = 4'h2,
        ST_CFG1 = 4'h3,
        ST_CFG2 = 4'h4,
        ST_CFG3 = 4'h5,
        ST_CFG4 = 4'h6,
        ST_SKIP = 4'h7,
        ST_PIXEL = 4'h8
    } cpsg_state_t;
endpackage : cpsg_pkg

//--- rtl/cpsg_pix_if.sv
// cpsg_pix_if: pixel path to the expander and window walker.
// assumes all three sit on one clock.
`timescale 1ns/1ns
`default_nettype none
interface cpsg_pix_if #(parameter int ADDR_W = 9);
    logic [15:0] pix565;
    logic [1:0] expand;
    logic [17:0] pix666;
    logic pix_valid;
    logic restart;
    logic wrap;
    logic keep;
    logic [ADDR_W-1:0] col_start, col_end, page_start, page_end;
    logic [ADDR_W-1:0] col, page;
    modport top (output pix565, expand, pix_valid, restart, wrap,
                 col_start, col_end, page_start, page_end,
                 input pix666, keep, col, page);
    modport expander (input pix565, expand, output pix666);
    modport walker (input pix_valid, restart, wrap, col_start, col_end,
                    page_start, page_end, output keep, col, page);
endinterface : cpsg_pix_if
`default_nettype wire

//--- rtl/cpsg_color_expand.sv
// cpsg_color_expand: widens a 5-6-5 pixel to 6-6-6.
// assumes the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module cpsg_color_expand (
    cpsg_pix_if.expander px
);
    function automatic logic [5:0] widen(input logic [1:0] code, input logic [4:0] v);
        case (code)
            // R16: copy msb down
            cpsg_pkg::EXP_MSB: widen = {v, v[4]};
            // R17: zero fill, full scale kept
            cpsg_pkg::EXP_ZERO: widen = (v == 5'h1f) ? 6'h3f : {v, 1'b0};
            // R18: one fill, zero kept
            cpsg_pkg::EXP_ONE: widen = (v == 5'h00) ? 6'h00 : {v, 1'b1};
            default: widen = {v, v[4]};
        endcase
    endfunction : widen

    assign px.pix666 = {widen(px.expand, px.pix565[15:11]), px.pix565[10:5],
                        widen(px.expand, px.pix565[4:0])};
endmodule : cpsg_color_expand
`default_nettype wire

//--- rtl/cpsg_window_walker.sv
// cpsg_window_walker: column and page pointers inside the write window.
// assumes restart pulses once per memory write command.
`timescale 1ns/1ns
`default_nettype none
module cpsg_window_walker #(parameter int ADDR_W = 9) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    cpsg_pix_if.walker px
);
    logic [ADDR_W-1:0] col_q, page_q;
    logic done_q;

    assign px.col = col_q;
    assign px.page = page_q;
    // R11: beyond the window, data dropped
    assign px.keep = !done_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            col_q <= '0;
            page_q <= '0;
            done_q <= 1'b0;
        end else if (px.restart) begin
            col_q <= px.col_start;
            page_q <= px.page_start;
            done_q <= 1'b0;
        end else if (px.pix_valid && !done_q) begin
            if (col_q == px.col_end) begin
                col_q <= px.col_start;
                if (page_q == px.page_end) begin
                    page_q <= px.page_start;
                    // R12: wrap to window start
                    done_q <= !px.wrap;
                end else begin
                    page_q <= page_q + 1'b1;
                end
            end else begin
                col_q <= col_q + 1'b1;
            end
        end
    end
endmodule : cpsg_window_walker
`default_nettype wire

//--- dv/cpsg_monitor.sv
// cpsg_monitor: port-level checks of the protect, standby and pixel paths.
// assumes it is bound into the top module and shares its ADDR_W.
`timescale 1ns/1ns
`default_nettype none
module cpsg_monitor #(parameter int ADDR_W = 9) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_chip_select_n,
    input wire logic i_cmd_data_select,
    input wire logic i_write_strobe,
    input wire logic [15:0] i_data,
    input wire logic i_sleep_in,
    input wire logic i_vblank,
    input wire logic [ADDR_W-1:0] i_window_col_start,
    input wire logic [ADDR_W-1:0] i_window_col_end,
    input wire logic [1:0] o_protect_level,
    input wire logic o_deep_sleep_req,
    input wire logic [2:0] o_frame_memory_write_cycle,
    input wire logic [3:0] o_write_cycle_frames,
    input wire logic [1:0] o_color_expand_format,
    input wire logic o_tear_output,
    input wire logic o_cmd_rejected,
    input wire logic o_pix_valid,
    input wire logic [17:0] o_pix_data,
    input wire logic [ADDR_W-1:0] o_pix_col
);
    logic strobe_q;
    logic take;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strobe_q <= 1'h1;
        end else begin
            strobe_q <= i_write_strobe;
        end
    end
    assign take = i_write_strobe & ~strobe_q & ~i_chip_select_n;
    function automatic logic blocked(input logic [1:0] l, input logic [7:0] c);
        return (l == 2'h3 && c >= 8'hb1) || (l == 2'h2 && c >= 8'he0) || (l == 2'h1 && c >= 8'hf0);
    endfunction : blocked
    function automatic logic [5:0] ext(input logic [4:0] v, input logic [1:0] e);
        case (e)
            2'h1: return (v == 5'h1f) ? 6'h3f : {v, 1'h0};
            2'h2: return (v == 5'h00) ? 6'h00 : {v, 1'h1};
            default: return {v, v[4]};
        endcase
    endfunction : ext
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    reset_clear_a: assert property (disable iff (1'h0) !i_reset_n |-> o_protect_level == 2'h0 && !o_deep_sleep_req)
        else $error("fields not cleared in reset");
    cycle_decode_a: assert property (o_write_cycle_frames ==
        ((o_frame_memory_write_cycle inside {3'h3, 3'h5, 3'h6, 3'h7}) ? 4'(o_frame_memory_write_cycle) + 4'h1 : 4'h0))
        else $error("write cycle decode wrong");
    reject_exact_a: assert property (take && !i_cmd_data_select && !o_deep_sleep_req |=>
        o_cmd_rejected == blocked($past(o_protect_level), $past(i_data[7:0])))
        else $error("reject pulse disagrees with level");
    reject_cause_a: assert property (o_cmd_rejected |-> $past(take && !i_cmd_data_select))
        else $error("reject without command byte");
    level_write_a: assert property ($changed(o_protect_level) |-> $past(take && i_cmd_data_select))
        else $error("level changed without parameter");
    standby_hold_a: assert property (o_deep_sleep_req |=> o_deep_sleep_req && !o_pix_valid && !o_cmd_rejected)
        else $error("activity in deep standby");
    tear_vblank_a: assert property (o_tear_output |-> $past(i_vblank && !i_sleep_in))
        else $error("tear outside blanking");
    pix_expand_a: assert property (o_pix_valid |-> o_pix_data == {ext($past(i_data[15:11]), o_color_expand_format),
        $past(i_data[10:5]), ext($past(i_data[4:0]), o_color_expand_format)}) else $error("bad colour expansion");
    pix_window_a: assert property (o_pix_valid |-> o_pix_col >= i_window_col_start && o_pix_col <= i_window_col_end)
        else $error("pixel outside window");
    pix_cause_a: assert property (o_pix_valid |-> $past(take && i_cmd_data_select))
        else $error("pixel without strobe");
    reject_c: cover property (o_cmd_rejected);
    wrap_c: cover property (o_pix_valid && o_pix_col == i_window_col_start);
    tear_c: cover property (o_tear_output);
    standby_c: cover property ($rose(o_deep_sleep_req));
endmodule : cpsg_monitor
`default_nettype wire

//--- dv/cpsg_host_model.sv
// cpsg_host_model: host side of the command bus, one byte per call.
// assumes the bench samples results at the falling edge after the call.
`timescale 1ns/1ns
`default_nettype none
module cpsg_host_model (
    input wire logic i_clk,
    output logic o_chip_select_n,
    output logic o_cmd_data_select,
    output logic o_write_strobe,
    output logic [15:0] o_data
);
    initial begin
        o_chip_select_n = 1'h0;
        o_cmd_data_select = 1'h0;
        o_write_strobe = 1'h0;
        o_data = 16'h0000;
    end
    task automatic wr(input logic dc, input logic [15:0] d);
        @(negedge i_clk);
        o_cmd_data_select = dc;
        o_data = d;
        o_write_strobe = 1'h1;
        @(negedge i_clk);
        o_write_strobe = 1'h0;
        o_data = ~d;
    endtask : wr
endmodule : cpsg_host_model
`default_nettype wire

//--- dv/cmd_protect_standby_frame_memory_cfg_tb.sv
// cmd_protect_standby_frame_memory_cfg_tb: command sequences with expected fields.
// assumes the host model drives the bus and the monitor is bound below.
`timescale 1ns/1ns
`default_nettype none
module cmd_protect_standby_frame_memory_cfg_tb;
    logic clk, rst_n, sleep, vbl, fs, cs_n, dcx, stb, dsr, wrap, fmt, tear, rej, pv;
    logic [15:0] dat;
    logic [1:0] lvl, color_expand_format;
    logic [2:0] tear_interval, cyc;
    logic [3:0] frm;
    logic [17:0] pd;
    logic [8:0] pc, pp, wcs, wce;
    logic [17:0] fld;
    int failures, checks;
    assign fld = {1'h0, lvl, dsr, wrap, tear_interval, cyc, frm, fmt, color_expand_format};
    cmd_protect_standby_frame_memory_cfg dut (.i_clk(clk), .i_reset_n(rst_n),
        .i_chip_select_n(cs_n), .i_cmd_data_select(dcx), .i_write_strobe(stb), .i_data(dat), .i_sleep_in(sleep),
        .i_vblank(vbl), .i_frame_start(fs), .i_window_col_start(wcs), .i_window_col_end(wce),
        .i_window_page_start(9'h5), .i_window_page_end(9'h6), .o_protect_level(lvl), .o_deep_sleep_req(dsr),
        .o_window_wrap_mode(wrap), .o_tear_interval(tear_interval), .o_frame_memory_write_cycle(cyc), .o_write_cycle_frames(frm),
        .o_pixel_transfer_format(fmt), .o_color_expand_format(color_expand_format), .o_tear_output(tear), .o_cmd_rejected(rej),
        .o_pix_valid(pv), .o_pix_data(pd), .o_pix_col(pc), .o_pix_page(pp));
    cpsg_host_model host (.i_clk(clk), .o_chip_select_n(cs_n), .o_cmd_data_select(dcx), .o_write_strobe(stb),
        .o_data(dat));
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] c, input logic [7:0] p);
        host.wr(1'h0, 16'(c));
        host.wr(1'h1, 16'(p));
    endtask : cmd
    task automatic cfg(input logic w, input logic [2:0] t, input logic [2:0] c, input logic [1:0] e, input logic f);
        host.wr(1'h0, 16'(cpsg_pkg::CMD_FRAME_MEMORY_CFG));
        host.wr(1'h1, {14'h0, w, 1'h0});
        host.wr(1'h1, {13'h0, t});
        host.wr(1'h1, {13'h0, c});
        host.wr(1'h1, {10'h0, e, 3'h0, f});
    endtask : cfg
    task automatic do_reset();
        rst_n = 1'h0;
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
    endtask : do_reset
    task automatic frames(input int n, output int cnt);
        logic prev = 1'h0;
        cnt = 0;
        for (int i = 0; i < n * 6; i++) begin
            fs = (i % 6 == 0);
            vbl = (i % 6 == 3) || (i % 6 == 4);
            @(negedge clk);
            if (tear === 1'h1 && prev !== 1'h1) cnt++;
            prev = tear;
        end
        fs = 1'h0;
        vbl = 1'h0;
    endtask : frames
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #4000000;
        failures++;
        final_report();
    end
    initial begin
        logic [1:0] lv[7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0};
        logic [7:0] code[7] = '{8'hf0, 8'hef, 8'he0, 8'hdf, 8'hb1, 8'h36, 8'hff};
        logic [6:0] blk = 7'h15;
        logic [2:0] cc[4] = '{3'h3, 3'h5, 3'h6, 3'h7};
        logic [3:0] fr[4] = '{4'h4, 4'h6, 4'h7, 4'h8};
        logic [2:0] tc[4] = '{3'h0, 3'h1, 3'h3, 3'h5};
        int tn[4] = '{1, 2, 4, 6};
        logic [15:0] px[4] = '{16'hffff, 16'h0000, 16'h8410, 16'h4208};
        logic [17:0] ex[3][4] = '{'{18'h3ffff, 18'h00000, 18'h21821, 18'h10410},
            '{18'h3ffff, 18'h00000, 18'h20820, 18'h10410}, '{18'h3ffff, 18'h00000, 18'h21821, 18'h11411}};
        logic [1:0] ee;
        int cnt;
        sleep = 1'h0;
        vbl = 1'h0;
        fs = 1'h0;
        wcs = 9'h3;
        wce = 9'h4;
        failures = 0;
        checks = 0;
        do_reset();
        check(fld, {1'h0, 2'h0, 1'h0, 1'h0, 3'h0, 3'h3, 4'h4, 1'h0, 2'h0});
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            cmd(cpsg_pkg::CMD_PROTECT, {6'h0, lv[i]});
            check(18'(lvl), 18'(lv[i]));
            host.wr(1'h0, 16'(code[i]));
            check(18'(rej), 18'(blk[i]));
            host.wr(1'h1, 16'h0001);
        end
        check(18'(dsr), 18'h0);
        cmd(cpsg_pkg::CMD_PROTECT, 8'h03);
        cfg(1'h1, 3'h5, 3'h7, 2'h2, 1'h1);
        check(fld, {1'h0, 2'h3, 1'h0, 1'h0, 3'h0, 3'h3, 4'h4, 1'h0, 2'h0});
        cmd(cpsg_pkg::CMD_PROTECT, 8'h00);
        $display("test protect done");
        for (int i = 0; i < 4; i++) begin
            sleep = i[0];
            cfg(1'h1, 3'h1, cc[i], 2'h2, 1'h1);
            check(fld, {1'h0, 2'h0, 1'h0, 1'h1, 3'h1, cc[i], fr[i], 1'h1, 2'h2});
        end
        sleep = 1'h0;
        $display("test setup done");
        for (int i = 0; i < 4; i++) begin
            cfg(1'h0, tc[i], 3'h3, 2'h0, 1'h0);
            frames(12, cnt);
            check(18'(cnt), 18'(12 / tn[i]));
        end
        sleep = 1'h1;
        frames(12, cnt);
        check(18'(cnt), 18'h0);
        sleep = 1'h0;
        $display("test tear done");
        for (int e = 0; e < 4; e++) begin
            ee = (e == 3) ? 2'h0 : 2'(e);
            cfg(e == 3, 3'h0, 3'h3, ee, 1'h0);
            host.wr(1'h0, 16'(cpsg_pkg::CMD_MEM_WRITE));
            for (int p = 0; p < 4; p++) begin
                host.wr(1'h1, px[p]);
                check(18'(pv), 18'h1);
                check(pd, ex[ee][p]);
                check({pc, pp}, {9'h3 + 9'(p % 2), 9'h5 + 9'(p / 2)});
            end
            host.wr(1'h1, px[0]);
            check(18'(pv), 18'(e == 3));
            if (e == 3) check({pc, pp}, {9'h3, 9'h5});
        end
        $display("test pixel done");
        sleep = 1'h1;
        cmd(cpsg_pkg::CMD_STANDBY, 8'h00);
        check(18'(dsr), 18'h0);
        cmd(cpsg_pkg::CMD_STANDBY, 8'h01);
        check(18'(dsr), 18'h1);
        host.wr(1'h0, 16'(cpsg_pkg::CMD_PROTECT));
        check({16'h0, pv, rej}, 18'h0);
        host.wr(1'h1, 16'h0002);
        check(18'(dsr), 18'h1);
        do_reset();
        check(fld, {1'h0, 2'h0, 1'h0, 1'h0, 3'h0, 3'h3, 4'h4, 1'h0, 2'h0});
        sleep = 1'h0;
        cfg(1'h1, 3'h5, 3'h7, 2'h1, 1'h1);
        check(fld, {1'h0, 2'h0, 1'h0, 1'h1, 3'h5, 3'h7, 4'h8, 1'h1, 2'h1});
        $display("test standby done");
        final_report();
    end
endmodule : cmd_protect_standby_frame_memory_cfg_tb
bind cmd_protect_standby_frame_memory_cfg cpsg_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
`default_nettype wire
